// *** rtl/rbac_rx_align.sv ***
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rbac_rx_align
  import rbac_pkg::*;
(
  input  wire logic       ref_clk,               // device clock, 100 MHz
  input  wire logic       rstn,                  // sync reset, active low
  input  wire logic [7:0] reg_addr,              // register address
  input  wire logic [7:0] reg_wdata,             // write data
  input  wire logic       reg_wr,                // write strobe
  input  wire logic       reg_rd,                // read strobe
  output logic      [7:0] reg_rdata,             // read data, cycle after strobe
  input  wire rbac_dec_t  dec_in,                // receive decoder stream
  output rbac_byte_t      byte_out,              // assembled bytes
  output logic            collision_flag,        // collision seen this reception
  output logic            integrity_error_flag,  // parity, crc or collision error
  output logic            irq                    // level interrupt
);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // address match used by both write and read decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // control fields of rx_bit_control
  logic       keep_bits_after_collision_q;
  logic [2:0] first_bit_offset_q;
  logic       collision_as_integrity_error_q;
  logic [2:0] last_byte_valid_bits_q;
  logic       bit_oriented;

  // internal status
  logic       collision_index_valid;
  logic [6:0] collision_index;
  logic [2:0] pack_pos;
  logic       coll_event;
  logic       integ_event;
  logic [2:0] irq_events;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_stat_d;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_mask_d;

  // mode select from the offset field
  assign bit_oriented = (first_bit_offset_q != 3'h0);

  // events of the current cycle
  assign coll_event  = dec_in.bit_valid & dec_in.bit_coll;
  assign integ_event = dec_in.integ_err | (coll_event & collision_as_integrity_error_q);

  // control register writes; last-bit field is not host writable
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      keep_bits_after_collision_q    <= RBAC_CTRL_RST[4];
      first_bit_offset_q             <= RBAC_CTRL_RST[3:1];
      collision_as_integrity_error_q <= RBAC_CTRL_RST[0];
    end
    else if (reg_wr && addr_hit(reg_addr, RBAC_ADDR_BIT_CTRL))
    begin
      keep_bits_after_collision_q    <= reg_wdata[RBAC_KEEP_BIT];
      first_bit_offset_q             <= reg_wdata[RBAC_OFFS_MSB:RBAC_OFFS_LSB];
      collision_as_integrity_error_q <= reg_wdata[RBAC_COLLISION_AS_INTEGRITY_ERROR_BIT];
    end
  end

  // last byte valid bits: set at end of bit mode exchange, cleared at start
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      last_byte_valid_bits_q <= 3'h0;
    else if (dec_in.start)
      last_byte_valid_bits_q <= 3'h0;
    else if (dec_in.frame_end && bit_oriented)
      last_byte_valid_bits_q <= pack_pos;  // zero when last byte full
  end

  // bit placement into bytes
  rbac_bit_packer u_packer (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .start     (dec_in.start),
    .offset    (first_bit_offset_q),
    .keep      (keep_bits_after_collision_q),
    .bit_valid (dec_in.bit_valid),
    .bit_value (dec_in.bit_value),
    .bit_coll  (dec_in.bit_coll),
    .frame_end (dec_in.frame_end),
    .byte_o    (byte_out),
    .pos_o     (pack_pos)
  );

  // first collision position tracking
  rbac_coll_index u_coll (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .start     (dec_in.start),
    .offset    (first_bit_offset_q),
    .bit_valid (dec_in.bit_valid),
    .bit_coll  (dec_in.bit_coll),
    .valid_o   (collision_index_valid),
    .index_o   (collision_index)
  );

  // error flags: set wins over the start clear
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      collision_flag       <= 1'b0;
      integrity_error_flag <= 1'b0;
    end
    else
    begin
      collision_flag       <= coll_event | (collision_flag & ~dec_in.start);
      integrity_error_flag <= integ_event | (integrity_error_flag & ~dec_in.start);
    end
  end

  // sticky interrupt status, cleared by read, set wins
  assign irq_events = {integ_event, coll_event, dec_in.frame_end};

  always_comb
  begin
    if (reg_rd && addr_hit(reg_addr, RBAC_ADDR_IRQ_STAT))
      irq_stat_d = irq_events;
    else
      irq_stat_d = irq_stat_q | irq_events;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      irq_stat_q <= 3'h0;
    else
      irq_stat_q <= irq_stat_d;
  end

  // next mask, shared with the interrupt line so both move on one edge
  always_comb
  begin
    if (reg_wr && addr_hit(reg_addr, RBAC_ADDR_IRQ_MASK))
      irq_mask_d = reg_wdata[2:0];
    else
      irq_mask_d = irq_mask_q;
  end

  // interrupt mask register
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      irq_mask_q <= RBAC_MASK_RST;
    else
      irq_mask_q <= irq_mask_d;
  end

  // interrupt line from next status and mask
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_d & irq_mask_d);  // no stale line after a mask write
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else if (addr_hit(reg_addr, RBAC_ADDR_BIT_CTRL))
      reg_rdata <= {keep_bits_after_collision_q, first_bit_offset_q,
                    collision_as_integrity_error_q, last_byte_valid_bits_q};
    else if (addr_hit(reg_addr, RBAC_ADDR_COLL_POS))
      reg_rdata <= {collision_index_valid, collision_index};
    else if (addr_hit(reg_addr, RBAC_ADDR_ERR_FLAGS))
      reg_rdata <= {5'h00, collision_flag, 1'b0, integrity_error_flag};
    else if (addr_hit(reg_addr, RBAC_ADDR_IRQ_STAT))
      reg_rdata <= {5'h00, irq_stat_q};
    else if (addr_hit(reg_addr, RBAC_ADDR_IRQ_MASK))
      reg_rdata <= {5'h00, irq_mask_q};
    else
      reg_rdata <= 8'h00;
  end

  // collision with integrity option raises the integrity flag
  property p_coll_integ;
    (coll_event && collision_as_integrity_error_q) |=> integrity_error_flag;
  endproperty
  a_coll_integ: assert property (p_coll_integ) else $error("collision did not raise integrity flag");

  // a collision sets the collision flag
  property p_coll_flag;
    coll_event |=> collision_flag;
  endproperty
  a_coll_flag: assert property (p_coll_flag) else $error("collision flag not set");

  // crc or parity error raises the integrity flag
  property p_integ_err;
    dec_in.integ_err |=> integrity_error_flag;
  endproperty
  a_integ_err: assert property (p_integ_err) else $error("integrity flag not set on error");

  // start clears the last-bit count
  property p_last_clear;
    (dec_in.start && !dec_in.frame_end) |=> (last_byte_valid_bits_q == 3'h0);
  endproperty
  a_last_clear: assert property (p_last_clear) else $error("last bit count not cleared");

  // end of bit mode exchange stores next free position
  property p_last_bits;
    (dec_in.frame_end && !dec_in.start && bit_oriented) |=> (last_byte_valid_bits_q == $past(pack_pos));
  endproperty
  a_last_bits: assert property (p_last_bits) else $error("last bit count wrong");

  // a valid index always lies within the first 64 bits
  property p_idx_range;
    collision_index_valid |-> (collision_index < RBAC_COLL_LIMIT);
  endproperty
  a_idx_range: assert property (p_idx_range) else $error("collision index out of range");

  // start leaves no stale index valid
  property p_idx_clear;
    (dec_in.start && !dec_in.bit_valid) |=> !collision_index_valid;
  endproperty
  a_idx_clear: assert property (p_idx_clear) else $error("stale collision index");

  // collision on first bit reports the offset as index
  property p_first_idx;
    (dec_in.start && !dec_in.bit_valid && !reg_wr) ##1
      (dec_in.bit_valid && dec_in.bit_coll && !dec_in.start)
      |=> (collision_index_valid && collision_index == {4'h0, $past(first_bit_offset_q, 2)});
  endproperty
  a_first_idx: assert property (p_first_idx) else $error("first collision index wrong");

  // first bit lands at offset, next position follows with wrap
  property p_align;
    (dec_in.start && !reg_wr) ##1 (dec_in.bit_valid && !dec_in.start)
      |=> (pack_pos == $past(first_bit_offset_q, 2) + 3'h1);
  endproperty
  a_align: assert property (p_align) else $error("bit alignment wrong");

  // with keep cleared, a bit landing at position 7 after a collision stores zero
  property p_zero_after;
    (collision_flag && !keep_bits_after_collision_q && !dec_in.start && dec_in.bit_valid
      && pack_pos == 3'h7 && !dec_in.bit_coll && $past(collision_flag))
      |=> (byte_out.valid && !byte_out.data[7]);
  endproperty
  a_zero_after: assert property (p_zero_after) else $error("bit after collision not zeroed");

  // interrupt follows masked status
  property p_irq;
    irq |-> (|(irq_stat_q & irq_mask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without masked status");

  // byte mode never reports partial last bits
  property p_byte_mode;
    (dec_in.frame_end && !bit_oriented && !dec_in.start && last_byte_valid_bits_q == 3'h0)
      |=> (last_byte_valid_bits_q == 3'h0);
  endproperty
  a_byte_mode: assert property (p_byte_mode) else $error("byte mode wrote last bits");

  // collision flag holds until the next reception starts
  property p_coll_hold;
    (collision_flag && !dec_in.start) |=> collision_flag;
  endproperty
  a_coll_hold: assert property (p_coll_hold) else $error("collision flag dropped early");

  // integrity flag holds while reception carries on
  property p_integ_hold;
    (integrity_error_flag && !dec_in.start) |=> integrity_error_flag;
  endproperty
  a_integ_hold: assert property (p_integ_hold) else $error("integrity flag dropped early");

  // start with no event clears both error flags
  property p_flag_clear;
    (dec_in.start && !dec_in.bit_valid && !dec_in.integ_err) |=> (!collision_flag && !integrity_error_flag);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("error flags not cleared at start");

  // only the first collision is recorded
  property p_idx_hold;
    (collision_index_valid && !dec_in.start) |=> (collision_index_valid && $stable(collision_index));
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("collision index moved");

  // offset field takes the written value
  property p_ctrl_wr;
    (reg_wr && addr_hit(reg_addr, RBAC_ADDR_BIT_CTRL))
      |=> (first_bit_offset_q == $past(reg_wdata[RBAC_OFFS_MSB:RBAC_OFFS_LSB]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("offset field not written");

  // host write leaves the last-bit count alone
  property p_last_ro;
    (reg_wr && addr_hit(reg_addr, RBAC_ADDR_BIT_CTRL) && !dec_in.start && !dec_in.frame_end)
      |=> $stable(last_byte_valid_bits_q);
  endproperty
  a_last_ro: assert property (p_last_ro) else $error("host changed last bit count");

  // host write leaves the collision position alone
  property p_idx_ro;
    (reg_wr && addr_hit(reg_addr, RBAC_ADDR_COLL_POS) && !dec_in.start && !dec_in.bit_valid)
      |=> ($stable(collision_index) && $stable(collision_index_valid));
  endproperty
  a_idx_ro: assert property (p_idx_ro) else $error("host changed collision position");

  // collision position read returns valid bit and index
  property p_coll_read;
    (reg_rd && addr_hit(reg_addr, RBAC_ADDR_COLL_POS))
      |=> (reg_rdata == {$past(collision_index_valid), $past(collision_index)});
  endproperty
  a_coll_read: assert property (p_coll_read) else $error("collision position read wrong");

  // read data is zero outside the answer cycle
  property p_rdata_idle;
    !reg_rd |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

  // status bit stays set until its register is read
  property p_stat_sticky;
    (irq_stat_q[RBAC_IRQ_INTEG] && !(reg_rd && addr_hit(reg_addr, RBAC_ADDR_IRQ_STAT)))
      |=> irq_stat_q[RBAC_IRQ_INTEG];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost before read");

endmodule : rbac_rx_align
`default_nettype wire

// *** rtl/rbac_pkg.sv ***
// shared constants and carriers for the receive bit alignment block
package rbac_pkg;

  // register offsets
  localparam logic [7:0] RBAC_ADDR_BIT_CTRL  = 8'h0c;
  localparam logic [7:0] RBAC_ADDR_COLL_POS  = 8'h0d;
  localparam logic [7:0] RBAC_ADDR_ERR_FLAGS = 8'h20;
  localparam logic [7:0] RBAC_ADDR_IRQ_STAT  = 8'h21;
  localparam logic [7:0] RBAC_ADDR_IRQ_MASK  = 8'h22;

  // rx_bit_control field positions
  localparam int RBAC_KEEP_BIT   = 7;
  localparam int RBAC_OFFS_MSB   = 6;
  localparam int RBAC_OFFS_LSB   = 4;
  localparam int RBAC_COLLISION_AS_INTEGRITY_ERROR_BIT = 3;

  // error flag and interrupt bit positions
  localparam int RBAC_ERR_INTEG  = 0;
  localparam int RBAC_ERR_COLL   = 2;
  localparam int RBAC_IRQ_DONE   = 0;
  localparam int RBAC_IRQ_COLL   = 1;
  localparam int RBAC_IRQ_INTEG  = 2;

  // reset values
  localparam logic [4:0] RBAC_CTRL_RST = 5'h00;
  localparam logic [2:0] RBAC_MASK_RST = 3'h0;

  // collision index range: first 8 bytes of data
  localparam logic [6:0] RBAC_COLL_LIMIT = 7'h40;

  // bit stream from the receive decoder
  typedef struct packed {
    logic start;      // reception starts
    logic bit_valid;  // one data bit this cycle
    logic bit_value;  // its value
    logic bit_coll;   // collision on this bit
    logic frame_end;  // end of exchange
    logic integ_err;  // parity or crc failure
  } rbac_dec_t;

  // assembled byte towards the fifo
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rbac_byte_t;

endpackage : rbac_pkg

// *** rtl/rbac_bit_packer.sv ***
`timescale 1ns/1ps
`default_nettype none
module rbac_bit_packer
  import rbac_pkg::*;
(
  input  wire logic       ref_clk,    // device clock
  input  wire logic       rstn,       // sync reset, active low
  input  wire logic       start,      // reception starts
  input  wire logic [2:0] offset,     // first bit position
  input  wire logic       keep,       // keep bits after collision
  input  wire logic       bit_valid,  // data bit strobe
  input  wire logic       bit_value,  // data bit
  input  wire logic       bit_coll,   // collision on bit
  input  wire logic       frame_end,  // end of exchange
  output rbac_byte_t      byte_o,     // assembled byte
  output logic      [2:0] pos_o       // next free bit position
);

  logic [7:0] acc_q;
  logic       coll_seen_q;
  logic       filled_q;
  logic       stored;
  logic [7:0] merged;

  // bits after a collision become zero unless kept
  always_comb
  begin
    stored         = bit_value & ~(coll_seen_q & ~keep);
    merged         = acc_q;
    merged[pos_o]  = stored;
  end

  // position and accumulator
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pos_o       <= 3'h0;
      acc_q       <= 8'h00;
      coll_seen_q <= 1'b0;
      filled_q    <= 1'b0;
    end
    else if (start)
    begin
      pos_o       <= offset;
      acc_q       <= 8'h00;
      coll_seen_q <= 1'b0;
      filled_q    <= 1'b0;
    end
    else if (bit_valid)
    begin
      pos_o       <= pos_o + 3'h1;  // wraps 7 to 0 of next byte
      acc_q       <= (pos_o == 3'h7) ? 8'h00 : merged;
      coll_seen_q <= coll_seen_q | bit_coll;
      filled_q    <= (pos_o != 3'h7);
    end
  end

  // byte output: full byte, or partial byte at frame end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      byte_o <= '0;
    else if (bit_valid && !start && pos_o == 3'h7)
      byte_o <= '{valid: 1'b1, data: merged};
    else if (frame_end && filled_q)
      byte_o <= '{valid: 1'b1, data: acc_q};
    else
      byte_o <= '{valid: 1'b0, data: byte_o.data};
  end

endmodule : rbac_bit_packer
`default_nettype wire

// *** rtl/rbac_coll_index.sv ***
`timescale 1ns/1ps
`default_nettype none
module rbac_coll_index
  import rbac_pkg::*;
(
  input  wire logic       ref_clk,    // device clock
  input  wire logic       rstn,       // sync reset, active low
  input  wire logic       start,      // reception starts
  input  wire logic [2:0] offset,     // first bit position
  input  wire logic       bit_valid,  // data bit strobe
  input  wire logic       bit_coll,   // collision on bit
  output logic            valid_o,    // index valid
  output logic      [6:0] index_o     // first collision index
);

  logic [6:0] cnt_q;
  logic       seen_q;

  // bit counter starting at the offset, saturating past the range
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      cnt_q <= 7'h00;
    else if (start)
      cnt_q <= {4'h0, offset};
    else if (bit_valid && cnt_q < RBAC_COLL_LIMIT)
      cnt_q <= cnt_q + 7'h01;
  end

  // capture first collision only
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      seen_q  <= 1'b0;
      valid_o <= 1'b0;
      index_o <= 7'h00;
    end
    else if (start)
    begin
      seen_q  <= 1'b0;
      valid_o <= 1'b0;
      index_o <= 7'h00;
    end
    else if (bit_valid && bit_coll && !seen_q)
    begin
      seen_q  <= 1'b1;
      valid_o <= (cnt_q < RBAC_COLL_LIMIT);
      index_o <= (cnt_q < RBAC_COLL_LIMIT) ? cnt_q : 7'h00;
    end
  end

endmodule : rbac_coll_index
`default_nettype wire

// *** tb/rbac_dec_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural receive decoder: start, bits, frame end
module rbac_dec_model
  import rbac_pkg::*;
(
  input  wire logic    ref_clk,  // device clock
  output var rbac_dec_t dec_o    // stream into the block
);
  initial dec_o = '0;

  // one frame; slow puts an idle cycle after every bit
  task automatic frame(input int n, input logic [71:0] b, input int cp, input bit err, input bit slow);
    @(posedge ref_clk);
    dec_o <= 6'b100000;
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      dec_o <= {2'b01, b[i], i == cp, 1'b0, err && i == 0};
      if (slow)
      begin
        @(posedge ref_clk);
        dec_o <= {2'b00, ~b[i], 3'b000}; // idle value toggles, not held
      end
    end
    @(posedge ref_clk);
    dec_o <= {2'b00, ~b[n-1], 3'b010}; // end of exchange
    @(posedge ref_clk);
    dec_o <= {2'b00, b[n-1], 3'b000};
  endtask : frame
endmodule : rbac_dec_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rbac_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rstn    = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  rbac_dec_t  dec;
  rbac_byte_t bo;
  logic       coll;
  logic       integ;
  logic       irq;
  logic [7:0] q[$];
  logic [7:0] d;
  int         n_fail = 0;
  int         samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  rbac_dec_model m (.ref_clk(ref_clk), .dec_o(dec));

  rbac_rx_align uut (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dec_in(dec),
    .byte_out(bo), .collision_flag(coll), .integrity_error_flag(integ), .irq(irq));

  // collect assembled bytes
  always @(posedge ref_clk)
    if (bo.valid === 1'b1)
      q.push_back(bo.data);

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // frame, then let the last byte and flags land
  task automatic run(input int n, input logic [71:0] b, input int cp, input bit err, input bit slow);
    q.delete();
    m.frame(n, b, cp, err, slow);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : run

  // reset values, read-only fields, unmapped address
  task automatic t_regs;
    rd(8'h0c, d); chk("ctrl rst", d, 8'h00);
    rd(8'h0d, d); chk("coll rst", d, 8'h00);
    rd(8'h30, d); chk("unmapped", d, 8'h00);
    wr(8'h0c, 8'hff);
    rd(8'h0c, d); chk("ctrl ro", d, 8'hf8);
    wr(8'h0d, 8'h55);
    rd(8'h0d, d); chk("coll ro", d, 8'h00);
    $display("done regs");
  endtask : t_regs

  // byte mode, kept bits after collision on bit 3
  task automatic t_byte;
    wr(8'h0c, 8'h80);
    rd(8'h21, d);
    run(8, 72'ha5, 3, 0, 1);
    chk("nbytes", q.size(), 8'h01);
    chk("byte", q[0], 8'ha5);
    chk("cflag", {7'h00, coll}, 8'h01);
    chk("iflag", {7'h00, integ}, 8'h00);
    rd(8'h0d, d); chk("index", d, 8'h83);
    if (d[7] === 1'b1) chk("index used", {1'b0, d[6:0]}, 8'h03);
    rd(8'h0c, d); chk("lastbits", d, 8'h80);
    rd(8'h20, d); chk("errs", d, 8'h04);
    $display("done byte");
  endtask : t_byte

  // offset 7 wraps, zero fill, collision as integrity error
  task automatic t_wrap;
    wr(8'h0c, 8'h78);
    run(2, 72'h3, 0, 0, 0);
    chk("nbytes", q.size(), 8'h02);
    chk("bit7", {7'h00, q[0][7]}, 8'h01);
    chk("zeroed", {7'h00, q[1][0]}, 8'h00);
    chk("iflag", {7'h00, integ}, 8'h01);
    rd(8'h0d, d); chk("index", d, 8'h87);
    rd(8'h0c, d); chk("lastbits", d, 8'h79);
    wr(8'h0c, 8'h00);
    run(8, 72'hff, 2, 0, 0);
    chk("zerofill", q[0], 8'h07);
    chk("iflag off", {7'h00, integ}, 8'h00);
    rd(8'h0d, d); chk("index2", d, 8'h82);
    $display("done wrap");
  endtask : t_wrap

  // offset 4, collision on 4th bit gives index 7
  task automatic t_align4;
    wr(8'h0c, 8'hc0);
    run(4, 72'ha, 3, 0, 0);
    chk("nbytes", q.size(), 8'h01);
    chk("upper", {4'h0, q[0][7:4]}, 8'h0a);
    rd(8'h0d, d); chk("index", d, 8'h87);
    rd(8'h0c, d); chk("whole", d, 8'hc0);
    $display("done align4");
  endtask : t_align4

  // last indexable bit, then one past the range
  task automatic t_range;
    wr(8'h0c, 8'h80);
    run(64, {9{8'h3c}}, 63, 0, 0);
    chk("nbytes", q.size(), 8'h08);
    rd(8'h0d, d); chk("index 63", d, 8'hbf);
    run(72, {9{8'h3c}}, 64, 0, 0);
    chk("byte9", q[8], 8'h3c);
    rd(8'h0d, d); chk("beyond", d, 8'h00);
    chk("cflag", {7'h00, coll}, 8'h01);
    $display("done range");
  endtask : t_range

  // integrity error keeps receiving; raise, mask, clear interrupt
  task automatic t_irq;
    wr(8'h0c, 8'h80);
    rd(8'h21, d);
    wr(8'h22, 8'h04);
    run(8, 72'h5a, -1, 1, 0);
    chk("byte", q[0], 8'h5a);
    chk("iflag", {7'h00, integ}, 8'h01);
    chk("cflag", {7'h00, coll}, 8'h00);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(8'h22, 8'h00);
    @(posedge ref_clk);
    #1 chk("masked", {7'h00, irq}, 8'h00);
    wr(8'h22, 8'h04);
    rd(8'h21, d); chk("status", d, 8'h05);
    @(posedge ref_clk);
    #1 chk("cleared", {7'h00, irq}, 8'h00);
    rd(8'h21, d); chk("status2", d, 8'h00);
    $display("done irq");
  endtask : t_irq

  // guard against a hang
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_byte();
    t_wrap();
    t_align4();
    t_range();
    t_irq();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
